// *** include/ace_defines.svh ***
`ifndef ACE_DEFINES_SVH
`define ACE_DEFINES_SVH
`define ACE_ADDR_W       12
`define ACE_OFF_CTRL     12'h000
`define ACE_OFF_LADDER   12'h004
`define ACE_OFF_IRQ_STAT 12'h008
`define ACE_OFF_IRQ_MASK 12'h00c
`define ACE_WORD_LSB     2
`define ACE_EDGE_LSB     3
`define ACE_EDGE_MSB     4
`define ACE_SYNC_BIT     6
`define ACE_VP_LSB       8
`define ACE_VP_MSB       10
`define ACE_VM_LSB       11
`define ACE_VM_MSB       13
`define ACE_CLR_BIT      20
`define ACE_LEVEL_BIT    21
`define ACE_FLAG_BIT     23
`define ACE_CTRL_WMASK   32'h0010_3f58
`define ACE_LAD_STEP_MSB 4
`define ACE_LAD_REF_BIT  5
`define ACE_LAD_WMASK    32'h0000_003f
`define ACE_REG_RESET    32'h0000_0000
`define ACE_IRQ_W        2
`define ACE_IRQ_RISE     0
`define ACE_IRQ_FALL     1
`define ACE_RESP_OKAY    2'h0
`define ACE_RESP_SLVERR  2'h2
`endif

// *** include/ace_pkg.sv ***
package ace_pkg;
   typedef enum logic [1:0] {
      ACE_EDGE_FALL  = 2'h0,
      ACE_EDGE_RISE  = 2'h1,
      ACE_EDGE_BOTH  = 2'h2,
      ACE_EDGE_BOTH3 = 2'h3
   } ace_edge_t;
   typedef enum logic [2:0] {
      ACE_SEL_LADDER  = 3'h0,
      ACE_SEL_EXT_ONE = 3'h1,
      ACE_SEL_EXT_TWO = 3'h2,
      ACE_SEL_BANDGAP = 3'h6
   } ace_sel_t;
   localparam int ACE_N_SRC = 4;
   localparam logic [2:0] ACE_SRC_CODE [ACE_N_SRC] =
      '{3'h0, 3'h1, 3'h2, 3'h6};
endpackage

// *** include/ace_if.sv ***
`timescale 1ns/100ps
interface ace_if;
   import ace_pkg::*;
   ace_edge_t edge_sel;
   logic      clr;
   logic      level;
   logic      rise;
   logic      fall;
   logic      flag;
   modport ctl (output edge_sel, clr, input level, rise, fall, flag);
   modport det (input edge_sel, clr, output level, rise, fall, flag);
endinterface

// *** core/ace_edge.sv ***
`timescale 1ns/100ps
module ace_edge (
   // clock and reset
   input  logic aclk,
   input  logic aresetn,
   // raw comparator level
   input  logic comparator_raw,
   // control side
   ace_if.det   e
);
   import ace_pkg::*;
   logic sync1_q;
   logic sync2_q;
   logic prev_q;
   logic flag_q;
   logic hit;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q  <= 1'b0;
      end else begin
         sync1_q <= comparator_raw;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q; // [RULE17]
      end
   end

   assign e.level = sync2_q;
   assign e.rise  = sync2_q & ~prev_q; // [RULE17]
   assign e.fall  = ~sync2_q & prev_q;

   always_comb begin
      case (e.edge_sel) // [RULE1]
         ACE_EDGE_FALL: hit = e.fall;
         ACE_EDGE_RISE: hit = e.rise;
         default:       hit = e.rise | e.fall;
      endcase
   end

   // set wins over clear
   always_ff @(posedge aclk) begin
      if (!aresetn)
         flag_q <= 1'b0;
      else if (hit)
         flag_q <= 1'b1; // [RULE2]
      else if (e.clr)
         flag_q <= 1'b0; // [RULE3]
   end
   assign e.flag = flag_q;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_flag_sticky: assert property ( // [RULE2]
      flag_q && !e.clr |=> flag_q)
      else $error("edge flag dropped without clear");
   a_rise_sets: assert property ( // [RULE1]
      e.rise && e.edge_sel == ACE_EDGE_RISE |=> flag_q)
      else $error("rising edge did not set flag");
   a_fall_only: assert property ( // [RULE1]
      !flag_q && e.rise && e.edge_sel == ACE_EDGE_FALL |=> !flag_q)
      else $error("rising edge set flag in falling mode");
   a_once_per_edge: assert property ( // [RULE17]
      e.rise |=> !e.rise)
      else $error("one transition seen twice");
endmodule // ace_edge

// *** core/ace_top.sv ***
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "ace_defines.svh"
// Function
// [RULE1]: edge select 0 falling, 1 rising, 2 and 3 both edges set flag.
// [RULE2]: edge flag is sticky and drives the interrupt request directly.
// [RULE3]: writing one to edge clear bit clears flag and request.
// [RULE4]: sync bit one passes bus-clock synchronised output, zero passes raw.
// [RULE5]: selected comparator output is offered for routing to a pin.
// [RULE6]: with sync zero and interrupt masked, output works without clock.
// [RULE7]: read-only control bit returns present comparator output level.
// [RULE8]: four sources reach two independent selectors, positive and negative.
// [RULE9]: code 0 ladder, 1 and 2 external, 6 reference, rest reserved.
// [RULE10]: ladder step selects one of 32 steps, reference down to ground.
// [RULE11]: ladder reference is main supply or dedicated reference pin.
// [RULE12]: software writes zero to reserved control bits.
// [RULE13]: software rereads output until readings agree after ladder changes.
// [RULE14]: software clears flag by writing one then zero to bit 20.
// [RULE15]: comparator output status sits at control bit 21.
// [RULE16]: positive selector bits 10:8, negative 13:11, same code meanings.
// [RULE17]: edges found by comparing consecutive bus-clock samples.
module ace_top #(
   parameter int LAD_STEPS = 32,
   parameter int LAD_W     = $clog2(LAD_STEPS)
) (
   // clock and reset
   input  logic                    aclk,
   input  logic                    aresetn,
   // axi4-lite write address
   input  logic [`ACE_ADDR_W-1:0]  s_axi_awaddr,
   input  logic [2:0]              s_axi_awprot,
   input  logic                    s_axi_awvalid,
   output logic                    s_axi_awready,
   // axi4-lite write data
   input  logic [31:0]             s_axi_wdata,
   input  logic [3:0]              s_axi_wstrb,
   input  logic                    s_axi_wvalid,
   output logic                    s_axi_wready,
   // axi4-lite write response
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  logic                    s_axi_bready,
   // axi4-lite read address
   input  logic [`ACE_ADDR_W-1:0]  s_axi_araddr,
   input  logic [2:0]              s_axi_arprot,
   input  logic                    s_axi_arvalid,
   output logic                    s_axi_arready,
   // axi4-lite read data
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  logic                    s_axi_rready,
   // analog comparator core
   input  logic                    comparator_raw,
   output ace_pkg::ace_sel_t       positive_input_select,
   output ace_pkg::ace_sel_t       negative_input_select,
   output logic [ace_pkg::ACE_N_SRC-1:0] positive_source_enable,
   output logic [ace_pkg::ACE_N_SRC-1:0] negative_source_enable,
   output logic [LAD_W-1:0]        ladder_step_select,
   output logic                    ladder_ref_pin_select,
   // comparator output to pin and other modules
   output logic                    comparator_out,
   // interrupts
   output logic                    edge_irq_req,
   output logic                    irq
);
   import ace_pkg::*;

   ace_if                  eif ();
   logic [31:0]            ctrl_q;
   logic [31:0]            ladder_q;
   logic [`ACE_IRQ_W-1:0]  stat_q;
   logic [`ACE_IRQ_W-1:0]  mask_q;
   logic                   aw_hold_q;
   logic                   w_hold_q;
   logic [`ACE_ADDR_W-1:0] awaddr_q;
   logic [31:0]            wdata_q;
   logic [3:0]             wstrb_q;
   logic                   bvalid_q;
   logic [1:0]             bresp_q;
   logic                   rvalid_q;
   logic [31:0]            rdata_q;
   logic [1:0]             rresp_q;
   logic                   wr_en;
   logic                   rd_en;
   logic [31:0]            wmask;
   logic [31:0]            wval;
   logic [`ACE_ADDR_W-1:0] wr_word;
   logic [`ACE_ADDR_W-1:0] rd_word;
   logic                   wr_ctrl;
   logic                   wr_lad;
   logic                   wr_stat;
   logic                   wr_mask;
   logic                   wr_hit;
   logic [31:0]            rd_val;
   logic                   rd_hit;
   logic [`ACE_IRQ_W-1:0]  events;

   ace_edge u_edge (
      .aclk           (aclk),
      .aresetn        (aresetn),
      .comparator_raw (comparator_raw),
      .e              (eif.det)
   );

   // write channel: address and data taken in either order
   assign s_axi_awready = !aw_hold_q && !bvalid_q;
   assign s_axi_wready  = !w_hold_q && !bvalid_q;
   assign wr_en         = aw_hold_q && w_hold_q && !bvalid_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         awaddr_q  <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_q <= 1'b1;
         awaddr_q  <= s_axi_awaddr;
      end else if (wr_en) begin
         aw_hold_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_hold_q <= 1'b0;
         wdata_q  <= '0;
         wstrb_q  <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_hold_q <= 1'b1;
         wdata_q  <= s_axi_wdata;
         wstrb_q  <= s_axi_wstrb;
      end else if (wr_en) begin
         w_hold_q <= 1'b0;
      end
   end

   // byte lanes to bit mask
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{wstrb_q[i]}};
      end
   end
   assign wval    = wdata_q & wmask;
   assign wr_word = {awaddr_q[`ACE_ADDR_W-1:`ACE_WORD_LSB],
                     `ACE_WORD_LSB'(0)};
   assign wr_ctrl = wr_en && wr_word == `ACE_OFF_CTRL;
   assign wr_lad  = wr_en && wr_word == `ACE_OFF_LADDER;
   assign wr_stat = wr_en && wr_word == `ACE_OFF_IRQ_STAT;
   assign wr_mask = wr_en && wr_word == `ACE_OFF_IRQ_MASK;
   assign wr_hit  = wr_ctrl | wr_lad | wr_stat | wr_mask;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `ACE_RESP_OKAY;
      end else if (wr_en) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_hit ? `ACE_RESP_OKAY : `ACE_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   // control register; reserved bits are dropped
   always_ff @(posedge aclk) begin
      if (!aresetn)
         ctrl_q <= `ACE_REG_RESET;
      else if (wr_ctrl)
         ctrl_q <= ((ctrl_q & ~wmask) | wval) & `ACE_CTRL_WMASK; // [RULE12]
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         ladder_q <= `ACE_REG_RESET;
      else if (wr_lad)
         ladder_q <= ((ladder_q & ~wmask) | wval) & `ACE_LAD_WMASK;
   end

   // flag clears on each write carrying a one in the clear bit, except when an edge hits in that same cycle
   assign eif.clr = wr_ctrl && wval[`ACE_CLR_BIT]; // [RULE3] [RULE14]
   assign eif.edge_sel =
      ace_edge_t'(ctrl_q[`ACE_EDGE_MSB:`ACE_EDGE_LSB]); // [RULE1]
   assign edge_irq_req = eif.flag; // [RULE2]

   // interrupt status: set wins over write-one-to-clear
   assign events[`ACE_IRQ_RISE] = eif.rise;
   assign events[`ACE_IRQ_FALL] = eif.fall;
   always_ff @(posedge aclk) begin
      if (!aresetn)
         stat_q <= '0;
      else if (wr_stat)
         stat_q <= events | (stat_q & ~wval[`ACE_IRQ_W-1:0]);
      else
         stat_q <= events | stat_q;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         mask_q <= '0;
      else if (wr_mask)
         mask_q <= (mask_q & ~wmask[`ACE_IRQ_W-1:0])
                   | wval[`ACE_IRQ_W-1:0];
   end
   assign irq = |(stat_q & mask_q);

   // read channel
   assign s_axi_arready = !rvalid_q;
   assign rd_en         = s_axi_arvalid && s_axi_arready;
   assign rd_word = {s_axi_araddr[`ACE_ADDR_W-1:`ACE_WORD_LSB],
                     `ACE_WORD_LSB'(0)};

   always_comb begin
      rd_val = '0;
      rd_hit = 1'b1;
      case (rd_word)
         `ACE_OFF_CTRL: begin
            rd_val = ctrl_q;
            rd_val[`ACE_LEVEL_BIT] = eif.level; // [RULE7] [RULE15]
            rd_val[`ACE_FLAG_BIT]  = eif.flag;
         end
         `ACE_OFF_LADDER:   rd_val = ladder_q;
         `ACE_OFF_IRQ_STAT: rd_val[`ACE_IRQ_W-1:0] = stat_q;
         `ACE_OFF_IRQ_MASK: rd_val[`ACE_IRQ_W-1:0] = mask_q;
         default:           rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= `ACE_RESP_OKAY;
      end else if (rd_en) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_val;
         rresp_q  <= rd_hit ? `ACE_RESP_OKAY : `ACE_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;

   // input selectors and per-source enables
   assign positive_input_select =
      ace_sel_t'(ctrl_q[`ACE_VP_MSB:`ACE_VP_LSB]); // [RULE16]
   assign negative_input_select =
      ace_sel_t'(ctrl_q[`ACE_VM_MSB:`ACE_VM_LSB]); // [RULE16]
   for (genvar s = 0; s < ACE_N_SRC; s++) begin : g_src
      // reserved codes enable no source
      assign positive_source_enable[s] =
         positive_input_select == ACE_SRC_CODE[s]; // [RULE8] [RULE9]
      assign negative_source_enable[s] =
         negative_input_select == ACE_SRC_CODE[s]; // [RULE8] [RULE9]
   end

   // ladder step and reference source
   assign ladder_step_select =
      ladder_q[`ACE_LAD_STEP_MSB:0]; // [RULE10]
   assign ladder_ref_pin_select = ladder_q[`ACE_LAD_REF_BIT]; // [RULE11]

   // raw path has no flop so it runs without the clock
   assign comparator_out = ctrl_q[`ACE_SYNC_BIT] ?
      eif.level : comparator_raw; // [RULE4] [RULE5] [RULE6]

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_irq_follows: assert property ( // [RULE2]
      (edge_irq_req == eif.flag) and
      (eif.flag && !eif.clr |=> edge_irq_req))
      else $error("interrupt request does not follow flag");
   a_clear_drops: assert property ( // [RULE3]
      eif.clr && !eif.rise && !eif.fall |=> !edge_irq_req)
      else $error("clear write left request high");
   a_both_edges: assert property ( // [RULE1]
      eif.fall && ctrl_q[`ACE_EDGE_MSB] |=> edge_irq_req)
      else $error("both-edge mode missed a falling edge");
   a_sync_path: assert property ( // [RULE4]
      ctrl_q[`ACE_SYNC_BIT] |-> comparator_out == eif.level)
      else $error("sync mode does not pass synchronised level");
   a_raw_path: assert property ( // [RULE6]
      !ctrl_q[`ACE_SYNC_BIT] |-> comparator_out == comparator_raw)
      else $error("direct mode does not pass raw level");
   a_level_read: assert property ( // [RULE7]
      rd_en && rd_word == `ACE_OFF_CTRL
      |=> s_axi_rdata[`ACE_LEVEL_BIT] == $past(eif.level))
      else $error("status bit does not show comparator level");
   a_sel_onehot: assert property ( // [RULE9]
      ($onehot0(positive_source_enable) && $onehot0(negative_source_enable))
      and (positive_input_select == ACE_SEL_BANDGAP
           |-> positive_source_enable[ACE_N_SRC-1]))
      else $error("selector decode wrong");
   a_reserved_zero: assert property ( // [RULE12]
      (ctrl_q & ~`ACE_CTRL_WMASK) == '0)
      else $error("reserved control bit stored");
   // bus answers come one cycle later and stand until taken
   a_write_answer: assert property (
      wr_en |=> s_axi_bvalid)
      else $error("write answer missing");
   a_write_holds: assert property (
      s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped before taken");
   a_read_answer: assert property (
      rd_en |=> s_axi_rvalid)
      else $error("read answer missing");
   a_ladder_write: assert property ( // [RULE10]
      wr_lad && wstrb_q[0]
      |=> ladder_step_select == $past(wdata_q[`ACE_LAD_STEP_MSB:0]))
      else $error("ladder step not updated");
   a_ref_select: assert property ( // [RULE11]
      wr_lad && wstrb_q[0]
      |=> ladder_ref_pin_select == $past(wdata_q[`ACE_LAD_REF_BIT]))
      else $error("ladder reference select not updated");
   a_neg_bandgap: assert property ( // [RULE9]
      negative_input_select == ACE_SEL_BANDGAP
      |-> negative_source_enable[ACE_N_SRC-1])
      else $error("negative bandgap source not enabled");
   a_sel_reserved: assert property ( // [RULE9]
      !(positive_input_select inside {ACE_SEL_LADDER, ACE_SEL_EXT_ONE,
                                      ACE_SEL_EXT_TWO, ACE_SEL_BANDGAP})
      |-> positive_source_enable == '0)
      else $error("reserved selector code enabled a source");
   a_level_sync: assert property ( // [RULE4]
      $past(aresetn) && $past(aresetn, 2)
      |-> eif.level == $past(comparator_raw, 2))
      else $error("level is not raw delayed by two flops");
   a_stat_sticky: assert property (
      stat_q[`ACE_IRQ_RISE] && !wr_stat |=> stat_q[`ACE_IRQ_RISE])
      else $error("rise status dropped without clear");


   c_rise_irq: cover property (
      eif.edge_sel == ACE_EDGE_RISE && eif.rise ##1 edge_irq_req);
   c_clear: cover property (edge_irq_req ##1 eif.clr ##1 !edge_irq_req);
   c_sync_on: cover property (
      wr_ctrl && wval[`ACE_SYNC_BIT] ##1 ctrl_q[`ACE_SYNC_BIT]);
   c_masked_irq: cover property (irq);
   c_fall_irq: cover property (
      eif.edge_sel == ACE_EDGE_FALL && eif.fall ##1 edge_irq_req);
endmodule // ace_top

// *** tb/ace_comp_model.sv ***
`timescale 1ns/100ps
module ace_comp_model
   import ace_pkg::*;
#(
   parameter int DLY_NS = 0,
   parameter int VDD_MV = 3300,
   parameter int BG_MV  = 900
) (
   // selector and ladder settings from the block
   input ace_sel_t    positive_input_select,
   input ace_sel_t    negative_input_select,
   input logic [4:0]  ladder_step_select,
   input logic        ladder_ref_pin_select,
   // pin voltages in millivolts
   input int          v_one,
   input int          v_two,
   input int          v_ref_pin,
   // comparator decision
   output logic       comparator_raw
);
   int ladder_setting;
   int vp;
   int vm;
   function automatic int pick(ace_sel_t c, int l, int a, int b);
      case (c)
         ACE_SEL_LADDER:  return l;
         ACE_SEL_EXT_ONE: return a;
         ACE_SEL_EXT_TWO: return b;
         ACE_SEL_BANDGAP: return BG_MV;
         default:         return 0;
      endcase
   endfunction
   always_comb begin
      // step 31 is the full reference, step 0 is ground
      ladder_setting = (ladder_ref_pin_select ? v_ref_pin : VDD_MV)
            * int'(ladder_step_select) / 31;
      vp  = pick(positive_input_select, ladder_setting, v_one, v_two);
      vm  = pick(negative_input_select, ladder_setting, v_one, v_two);
   end
   assign #(DLY_NS) comparator_raw = vp > vm;
endmodule // ace_comp_model

// *** tb/comparator_edge_control_tb_top.sv ***
`timescale 1ns/100ps
`include "ace_defines.svh"
module comparator_edge_control_tb_top;
   import ace_pkg::*;
   localparam logic [11:0] CT = `ACE_OFF_CTRL;
   localparam logic [11:0] LD = `ACE_OFF_LADDER;
   localparam logic [11:0] ST = `ACE_OFF_IRQ_STAT;
   localparam logic [11:0] MK = `ACE_OFF_IRQ_MASK;
   // positive from input one, negative from input two
   localparam logic [31:0] CB = 32'h0000_1100;
   localparam logic [31:0] CLR = 32'h0010_0000;
   localparam logic [2:0] CODES [5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h3};
   localparam logic [3:0] ENS [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
   // ladder settings: above, below, above input two
   localparam logic [31:0] LW [3] = '{32'h3f, 32'h26, 32'h06};
   localparam logic LV [3] = '{1'b1, 1'b0, 1'b1};
   logic aclk = 1'b0;
   logic aresetn;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp, rsp;
   logic raw, cmp_out, eirq, irq, ref_sel;
   ace_sel_t ps, ns;
   logic [3:0] pen, nen;
   logic [4:0] step;
   int v_one, v_two, v_ref;
   int bad_count = 0;
   int compares = 0;
   always #25 aclk = ~aclk;
   ace_top DUT (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .comparator_raw(raw),
      .positive_input_select(ps), .negative_input_select(ns),
      .positive_source_enable(pen), .negative_source_enable(nen),
      .ladder_step_select(step), .ladder_ref_pin_select(ref_sel),
      .comparator_out(cmp_out), .edge_irq_req(eirq), .irq(irq));
   ace_comp_model PM (.positive_input_select(ps),
      .negative_input_select(ns), .ladder_step_select(step),
      .ladder_ref_pin_select(ref_sel), .v_one(v_one), .v_two(v_two),
      .v_ref_pin(v_ref), .comparator_raw(raw));
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic axw(logic [11:0] a, logic [31:0] v);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid && n < 100);
      rsp = bresp;
      bready <= 1'b0;
      if (n >= 100) bad_count++;
   endtask
   task automatic axr(logic [11:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid && n < 100);
      d = rdata;
      rsp = rresp;
      rready <= 1'b0;
      if (n >= 100) bad_count++;
   endtask
   // flag clear: one then zero
   task automatic clr(logic [31:0] base);
      axw(CT, base | CLR);
      axw(CT, base);
   endtask
   task automatic t_regs;
      axr(CT); chk("ctrl reset", d, 32'h0);
      axr(LD); chk("ladder reset", d, 32'h0);
      axw(LD, 32'hffff_ffff);
      chk("write okay", 32'(rsp), 32'h0);
      axr(LD); chk("ladder rw", d, 32'h3f);
      chk("read okay", 32'(rsp), 32'h0);
      chk("step", 32'(step), 32'h1f);
      chk("ref pin", 32'(ref_sel), 32'h1);
      axw(CT, 32'h0000_3f58);
      axr(CT); chk("ctrl rw", d, 32'h0000_3f58);
      axr(12'h010); chk("unmapped rd", d, 32'h0);
      chk("unmapped rresp", 32'(rsp), 32'h2);
      axw(12'h010, 32'h1); chk("unmapped wr", 32'(rsp), 32'h2);
      axw(LD, 32'h0);
      $display("done regs");
   endtask
   task automatic t_sel;
      for (int i = 0; i < 5; i++) begin
         axw(CT, {18'h0, CODES[i], CODES[i], 8'h0});
         chk("pos sel", 32'(ps), 32'(CODES[i]));
         chk("neg sel", 32'(ns), 32'(CODES[i]));
         chk("pos en", 32'(pen), 32'(ENS[i]));
         chk("neg en", 32'(nen), 32'(ENS[i]));
      end
      $display("done sel");
   endtask
   // ladder against input two; reread until two readings agree
   task automatic t_ladder;
      logic lv;
      int k;
      axw(CT, 32'h0000_1000);
      for (int s = 0; s < 3; s++) begin
         axw(LD, LW[s]);
         axr(CT);
         k = 0;
         do begin
            lv = d[`ACE_LEVEL_BIT];
            axr(CT);
            k++;
         end while (d[`ACE_LEVEL_BIT] !== lv && k < 8);
         lv = d[`ACE_LEVEL_BIT];
         chk("ladder level", 32'(lv), 32'(LV[s]));
      end
      axw(LD, 32'h0);
      repeat (4) @(posedge aclk);
      clr(32'h0000_1000);
      chk("ladder clr", 32'(eirq), 32'h0);
      $display("done ladder");
   endtask
   task automatic t_edge;
      logic [31:0] wc;
      for (int e = 0; e < 4; e++) begin
         wc = CB | (32'(e) << `ACE_EDGE_LSB);
         clr(wc);
         v_one <= 900;
         repeat (5) @(posedge aclk);
         chk("rise flag", 32'(eirq), 32'(e != 0));
         axr(CT);
         chk("level", 32'(d[`ACE_LEVEL_BIT]), 32'h1);
         chk("sticky", 32'(d[`ACE_FLAG_BIT]), 32'(e != 0));
         clr(wc);
         chk("cleared", 32'(eirq), 32'h0);
         v_one <= 100;
         repeat (5) @(posedge aclk);
         chk("fall flag", 32'(eirq), 32'(e != 1));
         clr(wc);
      end
      $display("done edge");
   endtask
   task automatic t_sync;
      axw(CT, CB);
      @(posedge aclk);
      v_one <= 900;
      #1 chk("raw out", 32'(cmp_out), 32'h1);
      axw(CT, CB | 32'h40);
      @(posedge aclk);
      v_one <= 100;
      #1 chk("sync lag", 32'(cmp_out), 32'h1);
      repeat (3) @(posedge aclk);
      #1 chk("sync out", 32'(cmp_out), 32'h0);
      clr(CB);
      $display("done sync");
   endtask
   task automatic t_irq;
      axw(MK, 32'h0);
      axw(ST, 32'h3);
      v_one <= 900;
      repeat (5) @(posedge aclk);
      axr(ST); chk("stat rise", d, 32'h1);
      chk("irq masked", 32'(irq), 32'h0);
      axw(MK, 32'h1); chk("irq on", 32'(irq), 32'h1);
      axw(ST, 32'h1); chk("irq off", 32'(irq), 32'h0);
      axr(ST); chk("stat clr", d, 32'h0);
      $display("done irq");
   endtask
   initial begin
      aresetn = 1'b0;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      v_one = 100;
      v_two = 500;
      v_ref = 2000;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_sel;
      t_ladder;
      t_edge;
      t_sync;
      t_irq;
      final_report;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      final_report;
   end
endmodule // comparator_edge_control_tb_top
